// ==== design/disk_command_phase_decoder.sv ====
// command, execution and result phases of a disk controller command set
// assumes APB from software and drive-side logic on CORE_CLK_I
// Notes on behaviour
// - read-id opcode then select; keep identifier
// - read-id result: three status then CHRN
// - verify moves no data with the host
// - version query answers one byte 90h
// - write data forwards host bytes to drive
// - write deleted forwards host bytes to drive
// - verify and write results: status then CHRN
// - format takes six bytes, sector IDs, seven results
`timescale 1ns/1ps
module disk_command_phase_decoder (
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic IRQ_O,
	output logic EXEC_START_O,
	output fdc_cmd_pkg::exec_req_t EXEC_REQ_O,
	output logic [7:0] WR_DATA_O,
	output logic WR_VALID_O,
	input wire logic WR_READY_I,
	input wire logic EXEC_DONE_I,
	input wire fdc_cmd_pkg::exec_res_t EXEC_RES_I
);
	typedef struct packed {
		fdc_cmd_pkg::phase_t phase;
		fdc_cmd_pkg::cmd_kind_t kind;
		logic [8:0][7:0] cmd;
		logic [3:0] cnt;
		logic [3:0] need;
		logic [6:0][7:0] res;
		logic [2:0] res_len;
		logic [2:0] res_idx;
		logic [7:0] wr_data;
		logic wr_valid;
		logic start;
		logic [31:0] id;
	} core_state_t;

	core_state_t s_r;
	core_state_t s_nxt;
	fdc_cmd_pkg::apb_req_t req;
	fdc_cmd_pkg::cmd_kind_t new_kind;
	logic [3:0] new_len;
	logic [7:0] wbyte;
	logic [31:0] rdata;
	logic hold_ok;
	logic fire;
	logic wr_data_hit;
	logic rd_data_hit;
	logic rd_stat_hit;
	logic takes_data;
	logic [7:0] sel_mask;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;

	assign req.sel = PSEL_I;
	assign req.enable = PENABLE_I;
	assign req.write = PWRITE_I;
	assign req.addr = PADDR_I;
	assign req.wdata = PWDATA_I;
	assign wbyte = PWDATA_I[7:0];
	assign new_kind = fdc_cmd_pkg::decode_kind(wbyte);
	assign new_len = fdc_cmd_pkg::kind_len(new_kind);
	assign wr_data_hit = fire & PWRITE_I & (PADDR_I == fdc_cmd_pkg::OFS_DATA);
	assign rd_data_hit = fire & ~PWRITE_I & (PADDR_I == fdc_cmd_pkg::OFS_DATA);
	assign rd_stat_hit = fire & ~PWRITE_I &
		(PADDR_I == fdc_cmd_pkg::OFS_IRQ_STAT);
	// only bits actually returned are cleared; later events survive
	assign irq_clr = rd_stat_hit ? PRDATA_O[3:0] : 4'h0;
	// verify and read-id move nothing from the host during execution
	assign takes_data = (s_r.kind == fdc_cmd_pkg::K_WRITE) ||
		(s_r.kind == fdc_cmd_pkg::K_WRITE_DEL) ||
		(s_r.kind == fdc_cmd_pkg::K_FORMAT);
	// bit seven of the verify select byte is the count flag, not reserved
	assign sel_mask = (s_r.kind == fdc_cmd_pkg::K_VERIFY) ?
		fdc_cmd_pkg::SEL_MASK_EC : fdc_cmd_pkg::SEL_MASK;
	// a pending drive byte stalls the next data write on the bus
	assign hold_ok = ~(PWRITE_I && (PADDR_I == fdc_cmd_pkg::OFS_DATA) &&
		(s_r.phase == fdc_cmd_pkg::PH_EXEC) && s_r.wr_valid);

	fdc_apb_port u_port (
		.clk_i(CORE_CLK_I),
		.rst_n_i(ARST_N_I),
		.req_i(req),
		.hold_ok_i(hold_ok),
		.rdata_i(rdata),
		.prdata_o(PRDATA_O),
		.pready_o(PREADY_O),
		.pslverr_o(PSLVERR_O),
		.fire_o(fire)
	);

	fdc_irq #(
		.W(fdc_cmd_pkg::IRQ_W)
	) u_irq (
		.clk_i(CORE_CLK_I),
		.rst_n_i(ARST_N_I),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.mask_we_i(fire & PWRITE_I & (PADDR_I == fdc_cmd_pkg::OFS_IRQ_MASK)),
		.mask_d_i(PWDATA_I[3:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(IRQ_O)
	);

	always_comb
	begin
		if (PADDR_I == fdc_cmd_pkg::OFS_DATA)
			rdata = (s_r.phase == fdc_cmd_pkg::PH_RES) ?
				{24'h0, s_r.res[s_r.res_idx]} : 32'h0;
		else if (PADDR_I == fdc_cmd_pkg::OFS_PHASE)
			rdata = {24'h0, s_r.wr_valid, s_r.kind, s_r.phase};
		else if (PADDR_I == fdc_cmd_pkg::OFS_IRQ_STAT)
			rdata = {28'h0, irq_status};
		else if (PADDR_I == fdc_cmd_pkg::OFS_IRQ_MASK)
			rdata = {28'h0, irq_mask};
		else if (PADDR_I == fdc_cmd_pkg::OFS_ID)
			rdata = s_r.id;
		else
			rdata = 32'h0;
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		irq_set = 4'h0;
		if (s_r.wr_valid && WR_READY_I)
			s_nxt.wr_valid = 1'b0;
		case (s_r.phase)
		fdc_cmd_pkg::PH_IDLE:
			if (wr_data_hit)
			begin
				s_nxt.kind = new_kind;
				s_nxt.need = new_len;
				s_nxt.cmd = '0;
				s_nxt.cmd[0] = wbyte;
				s_nxt.cnt = 4'h1;
				s_nxt.res_idx = 3'h0;
				if (new_len == fdc_cmd_pkg::LEN_ONE)
				begin
					// one-byte commands skip straight to the result phase
					s_nxt.phase = fdc_cmd_pkg::PH_RES;
					s_nxt.res_len = fdc_cmd_pkg::RES_ONE;
					s_nxt.res[0] = (new_kind == fdc_cmd_pkg::K_VERSION) ?
						fdc_cmd_pkg::VERSION_REPLY :
						fdc_cmd_pkg::INVALID_ST0;
					irq_set[fdc_cmd_pkg::IRQ_RESULT] = 1'b1;
				end
				else
					s_nxt.phase = fdc_cmd_pkg::PH_CMD;
			end
		fdc_cmd_pkg::PH_CMD:
			if (wr_data_hit)
			begin
				s_nxt.cmd[s_r.cnt] = wbyte;
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == 4'h1 && (wbyte & sel_mask) != 8'h00)
					irq_set[fdc_cmd_pkg::IRQ_BAD_SEL] = 1'b1;
				if (s_r.cnt + 4'h1 == s_r.need)
				begin
					s_nxt.phase = fdc_cmd_pkg::PH_EXEC;
					s_nxt.start = 1'b1;
					irq_set[fdc_cmd_pkg::IRQ_START] = 1'b1;
				end
			end
		fdc_cmd_pkg::PH_EXEC:
		begin
			if (wr_data_hit)
			begin
				if (takes_data)
				begin
					s_nxt.wr_data = wbyte;
					s_nxt.wr_valid = 1'b1;
				end
				else
					irq_set[fdc_cmd_pkg::IRQ_REFUSED] = 1'b1;
			end
			if (EXEC_DONE_I)
			begin
				// a byte not yet taken by the drive is dropped at the end
				s_nxt.wr_valid = 1'b0;
				s_nxt.phase = fdc_cmd_pkg::PH_RES;
				s_nxt.res_len = fdc_cmd_pkg::RES_LONG;
				s_nxt.res_idx = 3'h0;
				s_nxt.res[0] = EXEC_RES_I.status_byte_zero;
				s_nxt.res[1] = EXEC_RES_I.status_byte_one;
				s_nxt.res[2] = EXEC_RES_I.status_byte_two;
				s_nxt.res[3] = EXEC_RES_I.cylinder;
				s_nxt.res[4] = EXEC_RES_I.head;
				s_nxt.res[5] = EXEC_RES_I.record;
				s_nxt.res[6] = EXEC_RES_I.size_code;
				irq_set[fdc_cmd_pkg::IRQ_RESULT] = 1'b1;
				if (s_r.kind == fdc_cmd_pkg::K_READ_ID)
					s_nxt.id = {EXEC_RES_I.cylinder, EXEC_RES_I.head,
						EXEC_RES_I.record, EXEC_RES_I.size_code};
			end
		end
		fdc_cmd_pkg::PH_RES:
		begin
			if (wr_data_hit)
				irq_set[fdc_cmd_pkg::IRQ_REFUSED] = 1'b1;
			if (rd_data_hit)
			begin
				s_nxt.res_idx = s_r.res_idx + 3'h1;
				if (s_r.res_idx + 3'h1 == s_r.res_len)
					s_nxt.phase = fdc_cmd_pkg::PH_IDLE;
			end
		end
		default:
			s_nxt.phase = fdc_cmd_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			s_r <= '0;
			s_r.phase <= fdc_cmd_pkg::PH_IDLE;
			s_r.kind <= fdc_cmd_pkg::K_INVALID;
		end
		else
			s_r <= s_nxt;
	end

	// drive-side view of the collected bytes
	always_comb
	begin
		EXEC_REQ_O = '0;
		EXEC_REQ_O.kind = s_r.kind;
		EXEC_REQ_O.multi_track_flag = s_r.cmd[0][7];
		EXEC_REQ_O.double_density_flag = s_r.cmd[0][6];
		EXEC_REQ_O.skip_deleted_flag = (s_r.kind == fdc_cmd_pkg::K_VERIFY) &
			s_r.cmd[0][5];
		EXEC_REQ_O.enable_count_flag = (s_r.kind == fdc_cmd_pkg::K_VERIFY) &
			s_r.cmd[1][7];
		EXEC_REQ_O.head_select = s_r.cmd[1][2];
		EXEC_REQ_O.drive_select_high = s_r.cmd[1][1];
		EXEC_REQ_O.drive_select_low = s_r.cmd[1][0];
		if (s_r.kind == fdc_cmd_pkg::K_FORMAT)
		begin
			EXEC_REQ_O.size_code = s_r.cmd[2];
			EXEC_REQ_O.sectors_per_cylinder = s_r.cmd[3];
			EXEC_REQ_O.gap_length = s_r.cmd[4];
			EXEC_REQ_O.filler_byte = s_r.cmd[5];
		end
		else
		begin
			EXEC_REQ_O.cylinder = s_r.cmd[2];
			EXEC_REQ_O.head = s_r.cmd[3];
			EXEC_REQ_O.record = s_r.cmd[4];
			EXEC_REQ_O.size_code = s_r.cmd[5];
			EXEC_REQ_O.final_sector_number = s_r.cmd[6];
			EXEC_REQ_O.gap_length = s_r.cmd[7];
			EXEC_REQ_O.data_length = s_r.cmd[8];
		end
	end

	assign EXEC_START_O = s_r.start;
	assign WR_DATA_O = s_r.wr_data;
	assign WR_VALID_O = s_r.wr_valid;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	sequence s_data_write;
		fire && PWRITE_I && (PADDR_I == fdc_cmd_pkg::OFS_DATA);
	endsequence

	sequence s_version_op;
		s_data_write ##0 (s_r.phase == fdc_cmd_pkg::PH_IDLE) &&
			(wbyte == fdc_cmd_pkg::OP_VERSION);
	endsequence

	sequence s_done_exec;
		EXEC_DONE_I && (s_r.phase == fdc_cmd_pkg::PH_EXEC);
	endsequence

	version_reply_a: assert property (
		s_version_op |=> (s_r.phase == fdc_cmd_pkg::PH_RES) &&
			(s_r.res[0] == fdc_cmd_pkg::VERSION_REPLY) &&
			(s_r.res_len == fdc_cmd_pkg::RES_ONE))
		else $error("version query gave wrong reply");

	read_id_store_a: assert property (
		s_done_exec ##0 (s_r.kind == fdc_cmd_pkg::K_READ_ID) |=>
			s_r.id == {$past(EXEC_RES_I.cylinder), $past(EXEC_RES_I.head),
			$past(EXEC_RES_I.record), $past(EXEC_RES_I.size_code)})
		else $error("identifier not stored after read id");

	result_order_a: assert property (
		s_done_exec |=> (s_r.res_len == fdc_cmd_pkg::RES_LONG) &&
			(s_r.res[0] == $past(EXEC_RES_I.status_byte_zero)) &&
			(s_r.res[3] == $past(EXEC_RES_I.cylinder)) &&
			(s_r.res[6] == $past(EXEC_RES_I.size_code)))
		else $error("result bytes out of order");

	verify_quiet_a: assert property (
		(s_r.phase == fdc_cmd_pkg::PH_EXEC) &&
			(s_r.kind == fdc_cmd_pkg::K_VERIFY) |-> !WR_VALID_O)
		else $error("verify moved data to the drive");

	count_flag_a: assert property (
		EXEC_START_O && (s_r.kind == fdc_cmd_pkg::K_VERIFY) |->
			(EXEC_REQ_O.enable_count_flag == s_r.cmd[1][7]) &&
			(EXEC_REQ_O.data_length == s_r.cmd[8]))
		else $error("verify count flag or length misplaced");

	bad_select_a: assert property (
		s_data_write ##0 (s_r.phase == fdc_cmd_pkg::PH_CMD) &&
			(s_r.cnt == 4'h1) && (s_r.kind != fdc_cmd_pkg::K_VERIFY) &&
			(wbyte[7:3] != 5'h00) |=> irq_status[fdc_cmd_pkg::IRQ_BAD_SEL])
		else $error("bad select byte not flagged");

	write_forward_a: assert property (
		s_data_write ##0 (s_r.phase == fdc_cmd_pkg::PH_EXEC) &&
			(s_r.kind == fdc_cmd_pkg::K_WRITE) && !EXEC_DONE_I |=>
			WR_VALID_O && (WR_DATA_O == $past(wbyte)))
		else $error("write data byte not forwarded");

	deleted_forward_a: assert property (
		s_data_write ##0 (s_r.phase == fdc_cmd_pkg::PH_EXEC) &&
			(s_r.kind == fdc_cmd_pkg::K_WRITE_DEL) && !EXEC_DONE_I |=>
			WR_VALID_O ##1 (WR_VALID_O || $past(WR_READY_I) ||
			$past(EXEC_DONE_I)))
		else $error("deleted data byte not forwarded");

	sector_len_a: assert property (
		EXEC_START_O && ((s_r.kind == fdc_cmd_pkg::K_VERIFY) ||
			(s_r.kind == fdc_cmd_pkg::K_WRITE) ||
			(s_r.kind == fdc_cmd_pkg::K_WRITE_DEL)) |->
			(s_r.cnt == fdc_cmd_pkg::LEN_SECTOR) && $past(s_r.cnt) == 4'h8)
		else $error("sector command started early");

	result_drain_a: assert property (
		(s_r.phase == fdc_cmd_pkg::PH_RES) && rd_data_hit &&
			(s_r.res_len == fdc_cmd_pkg::RES_LONG) && (s_r.res_idx == 3'h6)
			|=> (s_r.phase == fdc_cmd_pkg::PH_IDLE))
		else $error("result phase did not end after seventh byte");

	format_len_a: assert property (
		EXEC_START_O && (s_r.kind == fdc_cmd_pkg::K_FORMAT) |->
			(s_r.cnt == fdc_cmd_pkg::LEN_FORMAT) &&
			(EXEC_REQ_O.filler_byte == s_r.cmd[5]))
		else $error("format started with wrong byte count");
endmodule : disk_command_phase_decoder

// ==== include/fdc_cmd_pkg.sv ====
// register map, opcodes and carrier types of the disk command phase decoder
// assumes a 32-bit APB master and drive-side logic on the same clock
package fdc_cmd_pkg;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_PHASE = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_ID = 8'h10;
	localparam int unsigned IRQ_W = 4;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam int unsigned IRQ_START = 0;
	localparam int unsigned IRQ_RESULT = 1;
	localparam int unsigned IRQ_REFUSED = 2;
	localparam int unsigned IRQ_BAD_SEL = 3;
	localparam logic [7:0] OP_VERSION = 8'h10;
	localparam logic [7:0] VERSION_REPLY = 8'h90;
	localparam logic [7:0] INVALID_ST0 = 8'h80;
	localparam logic [7:0] DENSITY_IGNORE = 8'hBF;
	localparam logic [7:0] OP_READ_ID = 8'h0A;
	localparam logic [7:0] OP_FORMAT = 8'h0D;
	localparam logic [4:0] LOW_VERIFY = 5'h16;
	localparam logic [5:0] LOW_WRITE = 6'h05;
	localparam logic [5:0] LOW_WRITE_DEL = 6'h09;
	localparam logic [7:0] SEL_MASK = 8'hF8;
	localparam logic [7:0] SEL_MASK_EC = 8'h78;
	localparam logic [3:0] LEN_SECTOR = 4'h9;
	localparam logic [3:0] LEN_READ_ID = 4'h2;
	localparam logic [3:0] LEN_FORMAT = 4'h6;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [2:0] RES_LONG = 3'h7;
	localparam logic [2:0] RES_ONE = 3'h1;

	typedef enum logic [2:0] {K_INVALID, K_READ_ID, K_VERIFY, K_VERSION,
		K_WRITE, K_WRITE_DEL, K_FORMAT} cmd_kind_t;
	typedef enum logic [3:0] {PH_IDLE = 4'b0001, PH_CMD = 4'b0010,
		PH_EXEC = 4'b0100, PH_RES = 4'b1000} phase_t;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

	typedef struct packed {
		cmd_kind_t kind;
		logic multi_track_flag;
		logic double_density_flag;
		logic skip_deleted_flag;
		logic enable_count_flag;
		logic head_select;
		logic drive_select_high;
		logic drive_select_low;
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] record;
		logic [7:0] size_code;
		logic [7:0] final_sector_number;
		logic [7:0] gap_length;
		logic [7:0] data_length;
		logic [7:0] sectors_per_cylinder;
		logic [7:0] filler_byte;
	} exec_req_t;

	typedef struct packed {
		logic [7:0] status_byte_zero;
		logic [7:0] status_byte_one;
		logic [7:0] status_byte_two;
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] record;
		logic [7:0] size_code;
	} exec_res_t;

	function automatic cmd_kind_t decode_kind(input logic [7:0] op);
		cmd_kind_t k;
		k = K_INVALID;
		if ((op & DENSITY_IGNORE) == OP_READ_ID)
			k = K_READ_ID;
		else if ((op & DENSITY_IGNORE) == OP_FORMAT)
			k = K_FORMAT;
		else if (op[4:0] == LOW_VERIFY)
			k = K_VERIFY;
		else if (op[5:0] == LOW_WRITE)
			k = K_WRITE;
		else if (op[5:0] == LOW_WRITE_DEL)
			k = K_WRITE_DEL;
		else if (op == OP_VERSION)
			k = K_VERSION;
		return k;
	endfunction : decode_kind

	function automatic logic [3:0] kind_len(input cmd_kind_t k);
		logic [3:0] n;
		n = LEN_ONE;
		if (k == K_READ_ID)
			n = LEN_READ_ID;
		else if (k == K_FORMAT)
			n = LEN_FORMAT;
		else if (k == K_VERIFY || k == K_WRITE || k == K_WRITE_DEL)
			n = LEN_SECTOR;
		return n;
	endfunction : kind_len

	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_DATA || a == OFS_PHASE || a == OFS_IRQ_STAT ||
			a == OFS_IRQ_MASK || a == OFS_ID;
	endfunction : is_mapped
endpackage : fdc_cmd_pkg

// ==== design/fdc_apb_port.sv ====
// APB slave handshake: one wait state, more while hold_ok_i is low, registered read data
// assumes the master holds the request until pready is seen
`timescale 1ns/1ps
module fdc_apb_port (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire fdc_cmd_pkg::apb_req_t req_i,
	input wire logic hold_ok_i,
	input wire logic [31:0] rdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic fire_o
);
	typedef struct packed {
		logic ready;
		logic [31:0] rdata;
	} port_state_t;
	port_state_t s_r;
	port_state_t s_nxt;

	// read data is caught one edge before completion so it comes from a flop
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ready = req_i.sel & req_i.enable & ~s_r.ready & hold_ok_i;
		if (s_nxt.ready)
			s_nxt.rdata = req_i.write ? 32'h0 : rdata_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pready_o = s_r.ready;
	assign prdata_o = s_r.rdata;
	assign fire_o = req_i.sel & req_i.enable & s_r.ready;
	assign pslverr_o = s_r.ready & ~fdc_cmd_pkg::is_mapped(req_i.addr);
endmodule : fdc_apb_port

// ==== design/fdc_irq.sv ====
// sticky event bits, mask and one level interrupt
// assumes clear bits are exactly those software has just read
`timescale 1ns/1ps
module fdc_irq #(
	parameter int unsigned W = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	input wire logic mask_we_i,
	input wire logic [W-1:0] mask_d_i,
	output logic [W-1:0] status_o,
	output logic [W-1:0] mask_o,
	output logic irq_o
);
	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
		logic irq;
	} irq_state_t;
	irq_state_t s_r;
	irq_state_t s_nxt;

	// set beats clear so an event during the read is kept
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.status = (s_r.status & ~clr_i) | set_i;
		if (mask_we_i)
			s_nxt.mask = mask_d_i;
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_r.status <= '0;
			s_r.mask <= W'(fdc_cmd_pkg::IRQ_MASK_RST);
			s_r.irq <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	assign status_o = s_r.status;
	assign mask_o = s_r.mask;
	assign irq_o = s_r.irq;
endmodule : fdc_irq

// ==== dv/drive_model.sv ====
// behavioural drive-side logic facing the command decoder
// assumes one clock shared with the decoder and a bench that picks results
`timescale 1ns/1ps
module drive_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic exec_start_i,
	input wire logic wr_valid_i,
	input wire fdc_cmd_pkg::exec_res_t res_i,
	input wire logic [31:0] want_i,
	output logic wr_ready_o,
	output logic exec_done_o,
	output fdc_cmd_pkg::exec_res_t exec_res_o
);
	logic busy;
	int cnt;

	// outside the done cycle the result lines show the inverse, never stale
	assign exec_res_o = exec_done_o ? res_i : ~res_i;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy <= 1'b0;
			cnt <= 0;
			wr_ready_o <= 1'b0;
			exec_done_o <= 1'b0;
		end
		else
		begin
			exec_done_o <= 1'b0;
			// random stalls on the byte stream
			wr_ready_o <= busy & 1'($urandom);
			if (exec_start_i)
			begin
				busy <= 1'b1;
				cnt <= 0;
			end
			else if (busy)
			begin
				if ((want_i == 0) || (wr_valid_i && wr_ready_o))
					cnt <= cnt + 1;
				// a quiet run lasts long enough for a refused host byte
				if (cnt == ((want_i == 0) ? 8 : want_i))
				begin
					busy <= 1'b0;
					exec_done_o <= 1'b1;
				end
			end
		end
	end
endmodule : drive_model

// ==== dv/disk_command_phase_decoder_tb.sv ====
// self-checking bench: APB master, drive model, expected bytes in queues
// assumes the decoder assertions live in the design files
`timescale 1ns/1ps
module disk_command_phase_decoder_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, exec_start, wr_valid, wr_ready, exec_done;
	logic [7:0] wr_data;
	fdc_cmd_pkg::exec_req_t exec_req, req_cap;
	fdc_cmd_pkg::exec_res_t exec_res, res_v;
	int want = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	int st_cnt = 0;
	logic [7:0] got[$];
	logic [7:0] cq[$];
	logic [31:0] rq;
	logic re;
	logic [3:0] mask_v = 4'h0;

	always #2.5 core_clk = ~core_clk;

	disk_command_phase_decoder uut (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
		.EXEC_START_O(exec_start), .EXEC_REQ_O(exec_req),
		.WR_DATA_O(wr_data), .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready),
		.EXEC_DONE_I(exec_done), .EXEC_RES_I(exec_res));

	drive_model drv (.clk_i(core_clk), .rst_n_i(arst_n),
		.exec_start_i(exec_start), .wr_valid_i(wr_valid), .res_i(res_v),
		.want_i(want), .wr_ready_o(wr_ready), .exec_done_o(exec_done),
		.exec_res_o(exec_res));

	always @(posedge core_clk)
	begin
		if (exec_start === 1'b1)
		begin
			st_cnt++;
			req_cap = exec_req;
		end
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			got.push_back(wr_data);
	end

	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic run(input fdc_cmd_pkg::cmd_kind_t k, input int nd,
		input logic fwd, input logic [3:0] ie, input logic [3:0] care);
		fdc_cmd_pkg::exec_req_t e;
		fdc_cmd_pkg::exec_res_t r;
		logic [7:0] xq[$];
		logic [7:0] d;
		int s0;
		int n;
		r = fdc_cmd_pkg::exec_res_t'(56'({$urandom, $urandom}));
		res_v <= r;
		want <= fwd ? nd : 0;
		s0 = st_cnt;
		got.delete();
		foreach (cq[i])
			apb(1'b1, fdc_cmd_pkg::OFS_DATA, {24'h0, cq[i]});
		e = '0;
		e.kind = k;
		if (cq.size() > 1)
		begin
			for (n = 0; n < 50 && st_cnt == s0; n++)
				@(posedge core_clk);
			chk("exec start", s0 + 1, st_cnt);
			{e.multi_track_flag, e.double_density_flag} = cq[0][7:6];
			e.skip_deleted_flag = cq[0][5];
			e.enable_count_flag = (k == fdc_cmd_pkg::K_VERIFY) & cq[1][7];
			{e.head_select, e.drive_select_high} = cq[1][2:1];
			e.drive_select_low = cq[1][0];
			if (cq.size() == 9)
				{e.cylinder, e.head, e.record, e.size_code,
				e.final_sector_number, e.gap_length, e.data_length} =
				{cq[2], cq[3], cq[4], cq[5], cq[6], cq[7], cq[8]};
			if (k == fdc_cmd_pkg::K_FORMAT)
				{e.size_code, e.sectors_per_cylinder, e.gap_length,
				e.filler_byte} = {cq[2], cq[3], cq[4], cq[5]};
			cmp_count++;
			if (req_cap !== e)
			begin
				error_cnt++;
				$display("MISMATCH request expected %h seen %h", e, req_cap);
			end
		end
		for (n = 0; n < nd; n++)
		begin
			d = 8'($urandom);
			apb(1'b1, fdc_cmd_pkg::OFS_DATA, {24'h0, d});
			if (fwd)
				xq.push_back(d);
		end
		n = 0;
		do
		begin
			apb(1'b0, fdc_cmd_pkg::OFS_PHASE, 32'h0);
			n++;
		end
		while (rq[3:0] !== 4'h8 && n < 60);
		chk("result phase", 32'h8, {28'h0, rq[3:0]});
		chk("stream count", xq.size(), got.size());
		foreach (xq[i])
			chk("stream byte", xq[i], got[i]);
		chk("irq line", {31'h0, |(ie & care & mask_v)}, {31'h0, irq});
		if (cq.size() == 1)
		begin
			apb(1'b0, fdc_cmd_pkg::OFS_DATA, 32'h0);
			d = (k == fdc_cmd_pkg::K_VERSION) ? 8'h90 : 8'h80;
			chk("one byte result", {24'h0, d}, rq);
		end
		else
			for (n = 0; n < 7; n++)
			begin
				apb(1'b0, fdc_cmd_pkg::OFS_DATA, 32'h0);
				chk("result byte", {24'h0, r[55-8*n -: 8]}, rq);
			end
		apb(1'b0, fdc_cmd_pkg::OFS_PHASE, 32'h0);
		chk("idle phase", 32'h1, {28'h0, rq[3:0]});
		if (k == fdc_cmd_pkg::K_READ_ID)
		begin
			apb(1'b0, fdc_cmd_pkg::OFS_ID, 32'h0);
			chk("stored id", r[31:0], rq);
		end
		apb(1'b0, fdc_cmd_pkg::OFS_IRQ_STAT, 32'h0);
		chk("irq status", {28'h0, ie & care}, {28'h0, rq[3:0] & care});
		// the interrupt flop only drops on the completing edge itself
		@(negedge core_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test done kind %0d", k);
	endtask : run

	initial
	begin
		#100us;
		error_cnt++;
		summarize();
	end

	initial
	begin
		void'($urandom(32'hBA0B5E33));
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		apb(1'b0, fdc_cmd_pkg::OFS_PHASE, 32'h0);
		chk("reset phase", 32'h1, rq);
		apb(1'b0, fdc_cmd_pkg::OFS_IRQ_MASK, 32'h0);
		chk("reset mask", 32'h0, rq);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, {rq[30:0], re});
		$display("test done registers");
		cq = '{fdc_cmd_pkg::OP_VERSION};
		run(fdc_cmd_pkg::K_VERSION, 0, 1'b0, 4'h2, 4'hE);
		cq = '{8'h1F};
		run(fdc_cmd_pkg::K_INVALID, 0, 1'b0, 4'h2, 4'hE);
		apb(1'b1, fdc_cmd_pkg::OFS_IRQ_MASK, 32'h2);
		mask_v = 4'h2;
		for (int i = 0; i < 2; i++)
		begin
			cq = '{{1'b0, 1'(i), 6'h0A}, {5'h0, 3'($urandom)}};
			run(fdc_cmd_pkg::K_READ_ID, 0, 1'b0, 4'h3, 4'hF);
		end
		// a data byte during verify must be refused, never streamed
		cq = '{{3'($urandom), 5'h16}, {1'($urandom), 4'h0, 3'($urandom)}};
		repeat (7) cq.push_back(8'($urandom));
		run(fdc_cmd_pkg::K_VERIFY, 1, 1'b0, 4'h7, 4'hF);
		cq = '{{2'($urandom), 6'h05}, {5'h0, 3'($urandom)}};
		repeat (7) cq.push_back(8'($urandom));
		run(fdc_cmd_pkg::K_WRITE, 3, 1'b1, 4'h3, 4'hF);
		// malformed select byte is flagged yet still decoded
		cq = '{{2'($urandom), 6'h09}, {5'h05, 3'($urandom)}};
		repeat (7) cq.push_back(8'($urandom));
		run(fdc_cmd_pkg::K_WRITE_DEL, 2, 1'b1, 4'hB, 4'hF);
		cq = '{{1'b0, 1'($urandom), 6'h0D}, {5'h0, 3'($urandom)},
			8'($urandom), 8'h01, 8'($urandom), 8'($urandom)};
		run(fdc_cmd_pkg::K_FORMAT, 4, 1'b1, 4'h3, 4'hF);
		summarize();
	end
endmodule : disk_command_phase_decoder_tb
